// >>> sideband_pkg.sv
// sideband pin multiplexer constants: register map, function codes, reset values
// assumes a single 40 MHz clock domain and the plain strobe register port
//
// Overview of operation
// - coexistence mode drives wlan busy during transmit
// - pin five defaults to host powersave wake
// - uart mode: send only once host ready
// - wake-on-wireless makes priority pin an output
// - sleep flag low in deep sleep, high after
// - power gate enable active high, high at power-up
// - bypass high during boot is latched and flagged
// - bypass high after boot wakes deep sleep
// - clock-input mode samples slow external clock
// - debug serial output is the default function
// - defaults apply only after boot completes
package sideband_pkg;
	// register offsets (word index)
	localparam logic [3:0] REG_FUNC_SEL = 4'h0; // function select fields
	localparam logic [3:0] REG_CTRL = 4'h1; // control bits
	localparam logic [3:0] REG_STATUS = 4'h2; // pin and state readback
	localparam logic [3:0] REG_IRQ_STAT = 4'h3; // sticky events, write one to clear
	localparam logic [3:0] REG_IRQ_MASK = 4'h4; // interrupt enables
	// function select field positions
	localparam int FS_DATA3 = 0; // 0 sdio, 1 spi interrupt
	localparam int FS_GPIO0 = 1; // 0 hi-z, 1 wlan busy
	localparam int FS_GPIO1 = 2; // 0 hi-z, 1 bluetooth busy input
	localparam int FS_PIN5 = 3; // 0 powersave wake, 1 host ready
	localparam int FS_GPIO6 = 4; // 0 hi-z, 1 priority input, 2 wake output (2 bits)
	localparam int FS_GPIO9 = 6; // 0 debug serial, 1 hi-z
	localparam int FS_BATT0 = 7; // 0 power gate, 1 sleep flag
	localparam int FS_BATT3 = 8; // 0 hi-z, 1 slow clock, 2 sleep flag (2 bits)
	localparam logic [9:0] FUNC_SEL_RESET = 10'h000;
	// control bit positions
	localparam int CT_BOOT_DONE = 0; // firmware loaded, defaults in force
	localparam int CT_WLAN_TX = 1; // own transmission in progress
	localparam int CT_DEEP_SLEEP = 2; // in ultra-low-power sleep
	localparam int CT_SPI_IRQ = 3; // interrupt request toward host
	localparam int CT_HOST_WAKE = 4; // wake request toward host
	localparam int CT_PKT_REQ = 5; // packet waiting for host
	localparam logic [5:0] CTRL_RESET = 6'h00;
	// event bit positions
	localparam int EV_HOST_WAKE = 0;
	localparam int EV_BT_PRIO = 1;
	localparam int EV_DEEP_WAKE = 2;
	localparam int EV_BYPASS = 3;
	localparam int EV_PKT_SENT = 4;
	localparam int EV_W = 5;
	// three-way select codes
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_A = 2'h1;
	localparam logic [1:0] SEL_B = 2'h2;
endpackage : sideband_pkg

// >>> sync2.sv
// two-flop synchroniser for one pin input
// assumes an asynchronous active-low reset
`timescale 1ns/10ps
module sync2 (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta; // first stage, read only by the second
	// two stages in series
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta <= 1'b0;
			q_o <= 1'b0;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule : sync2

// >>> sideband_pins.sv
// sideband pin multiplexer: coexistence, wake handshakes, sleep flag, power gate
// assumes pin inputs are asynchronous; the bus master is on mclk_i
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module sideband_pins
	import sideband_pkg::*;
(
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic irq_o,
	input wire logic spi_mode_i, // host interface is spi
	input wire logic uart_mode_i, // host interface is uart
	input wire logic debug_serial_i, // debug uart transmit data
	output logic pkt_send_o, // packet handed to host
	output logic slow_clock_o, // synchronised slow clock
	input wire logic sdio_data3_i,
	output logic sdio_data3_o,
	output logic sdio_data3_oe_o,
	input wire logic low_power_pin_zero_i,
	output logic low_power_pin_zero_o,
	output logic low_power_pin_zero_oe_o,
	input wire logic low_power_pin_one_i,
	output logic low_power_pin_one_oe_o,
	input wire logic low_power_pin_five_i,
	output logic low_power_pin_five_oe_o,
	input wire logic low_power_pin_six_i,
	output logic low_power_pin_six_o,
	output logic low_power_pin_six_oe_o,
	output logic low_power_pin_nine_o,
	output logic low_power_pin_nine_oe_o,
	output logic battery_domain_pin_zero_o,
	output logic battery_domain_pin_zero_oe_o,
	input wire logic battery_domain_pin_two_i,
	input wire logic battery_domain_pin_three_i,
	output logic battery_domain_pin_three_o,
	output logic battery_domain_pin_three_oe_o
);
	////////////////////////////////////////////////////////////////////////////
	// pin input synchronisers
	localparam int NIN = 5;
	logic [NIN-1:0] pin_raw; // raw pin levels
	logic [NIN-1:0] pin_s; // synchronised levels
	assign pin_raw = {battery_domain_pin_three_i, battery_domain_pin_two_i,
		low_power_pin_six_i, low_power_pin_five_i, low_power_pin_one_i};
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			sync2 u_sync (
				.mclk_i(mclk_i),
				.nrst_i(nrst_i),
				.d_i(pin_raw[gi]),
				.q_o(pin_s[gi])
			);
		end
	endgenerate
	logic bluetooth_tx_busy_in;
	logic host_powersave_wake_in; // pin five, default function
	logic bluetooth_high_prio_in;
	logic boot_bypass_in; // same pin serves as deep_sleep_wake_in
	logic slow_clock_in;
	assign bluetooth_tx_busy_in = pin_s[0];
	assign host_powersave_wake_in = pin_s[1];
	assign bluetooth_high_prio_in = pin_s[2];
	assign boot_bypass_in = pin_s[3];
	assign slow_clock_in = pin_s[4];

	////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [9:0] func_sel; // per-pin function select
		logic [5:0] ctrl; // control bits
		logic [EV_W-1:0] irq_stat; // sticky events
		logic [EV_W-1:0] irq_mask; // enables
		logic [NIN-1:0] pin_q; // previous sync levels, edge detect
		logic [31:0] rdata;
		logic irq;
		logic pkt_send;
		logic slow_clk;
		logic bypass_latched; // bypass seen during boot
		logic d3_o, d3_oe, g0_o, g0_oe, g1_oe, g5_oe, g6_o, g6_oe;
		logic g9_o, g9_oe, b0_o, b0_oe, b3_o, b3_oe;
	} state_t;
	state_t st;
	state_t next_st;

	localparam state_t ST_RESET = '{func_sel: FUNC_SEL_RESET, ctrl: CTRL_RESET,
		b0_o: 1'b1, b0_oe: 1'b1, default: '0};

	// convenience views of control and selects
	logic boot_done, wlan_tx, deep_sleep;
	logic sel_spi_d3, sel_g0, sel_g1, sel_hostrdy, sel_g9_off, sel_b0_sleep;
	logic [1:0] sel_g6, sel_b3;
	assign boot_done = st.ctrl[CT_BOOT_DONE];
	assign wlan_tx = st.ctrl[CT_WLAN_TX];
	assign deep_sleep = st.ctrl[CT_DEEP_SLEEP];
	assign sel_spi_d3 = st.func_sel[FS_DATA3];
	assign sel_g0 = st.func_sel[FS_GPIO0];
	assign sel_g1 = st.func_sel[FS_GPIO1];
	assign sel_hostrdy = st.func_sel[FS_PIN5];
	assign sel_g6 = st.func_sel[FS_GPIO6 +: 2];
	assign sel_g9_off = st.func_sel[FS_GPIO9];
	assign sel_b0_sleep = st.func_sel[FS_BATT0];
	assign sel_b3 = st.func_sel[FS_BATT3 +: 2];

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		logic [EV_W-1:0] ev;
		logic [EV_W-1:0] clr;
		ev = '0;
		clr = '0;
		next_st = st;
		next_st.pin_q = pin_s;
		next_st.pkt_send = 1'b0;
		next_st.rdata = '0;
		// register writes
		if (wr_i) begin
			case (addr_i)
				REG_FUNC_SEL: next_st.func_sel = wdata_i[9:0];
				REG_CTRL: next_st.ctrl = wdata_i[5:0];
				REG_IRQ_STAT: clr = wdata_i[EV_W-1:0];
				REG_IRQ_MASK: next_st.irq_mask = wdata_i[EV_W-1:0];
				default: ;
			endcase
		end
		// register reads, data in the following cycle
		if (rd_i) begin
			case (addr_i)
				REG_FUNC_SEL: next_st.rdata = {22'h0, st.func_sel};
				REG_CTRL: next_st.rdata = {26'h0, st.ctrl};
				REG_STATUS: next_st.rdata = {26'h0, st.bypass_latched, pin_s};
				REG_IRQ_STAT: next_st.rdata = {27'h0, st.irq_stat};
				REG_IRQ_MASK: next_st.rdata = {27'h0, st.irq_mask};
				default: next_st.rdata = '0;
			endcase
		end
		// pin events: rising edges for selected functions and deep wake, first bypass high during boot
		if (boot_done && !sel_hostrdy && host_powersave_wake_in && !st.pin_q[1]) begin
			ev[EV_HOST_WAKE] = 1'b1;
		end
		if (sel_g6 == SEL_A && bluetooth_high_prio_in && !st.pin_q[2]) begin
			ev[EV_BT_PRIO] = 1'b1;
		end
		if (!boot_done && boot_bypass_in) begin
			next_st.bypass_latched = 1'b1;
			ev[EV_BYPASS] = !st.bypass_latched;
		end
		if (boot_done && deep_sleep && boot_bypass_in && !st.pin_q[3]) begin
			ev[EV_DEEP_WAKE] = 1'b1;
			next_st.ctrl[CT_DEEP_SLEEP] = 1'b0;
		end
		// uart packet handshake: send once host ready
		if (uart_mode_i && sel_hostrdy && boot_done && st.ctrl[CT_PKT_REQ]
			&& host_powersave_wake_in) begin
			next_st.pkt_send = 1'b1;
			next_st.ctrl[CT_PKT_REQ] = 1'b0;
			ev[EV_PKT_SENT] = 1'b1;
		end
		// set wins over clear
		next_st.irq_stat = (st.irq_stat & ~clr) | ev;
		next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
		next_st.slow_clk = (sel_b3 == SEL_A) ? slow_clock_in : 1'b0;

		// pin drive; before boot completes all keep power-up states
		next_st.d3_o = 1'b0;
		next_st.d3_oe = 1'b0;
		next_st.g0_o = 1'b0;
		next_st.g0_oe = 1'b0;
		next_st.g1_oe = 1'b0;
		next_st.g5_oe = 1'b0;
		next_st.g6_o = 1'b0;
		next_st.g6_oe = 1'b0;
		next_st.g9_o = 1'b0;
		next_st.g9_oe = 1'b0;
		next_st.b0_o = 1'b1;
		next_st.b0_oe = 1'b1;
		next_st.b3_o = 1'b0;
		next_st.b3_oe = 1'b0;
		if (next_st.ctrl[CT_BOOT_DONE]) begin
			if (spi_mode_i && sel_spi_d3) begin
				next_st.d3_o = next_st.ctrl[CT_SPI_IRQ];
				next_st.d3_oe = 1'b1;
			end
			if (sel_g0) begin
				next_st.g0_o = next_st.ctrl[CT_WLAN_TX];
				next_st.g0_oe = 1'b1;
			end
			if (sel_g6 == SEL_B) begin
				next_st.g6_o = next_st.ctrl[CT_HOST_WAKE];
				next_st.g6_oe = 1'b1;
			end
			if (!sel_g9_off) begin
				next_st.g9_o = debug_serial_i;
				next_st.g9_oe = 1'b1;
			end
			if (sel_b0_sleep) begin
				next_st.b0_o = !next_st.ctrl[CT_DEEP_SLEEP];
			end else begin
				next_st.b0_o = !next_st.ctrl[CT_DEEP_SLEEP]; // gate off in sleep
			end
			if (sel_b3 == SEL_B) begin
				next_st.b3_o = !next_st.ctrl[CT_DEEP_SLEEP];
				next_st.b3_oe = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, straight from flops
	assign rdata_o = st.rdata;
	assign irq_o = st.irq;
	assign pkt_send_o = st.pkt_send;
	assign slow_clock_o = st.slow_clk;
	assign sdio_data3_o = st.d3_o;
	assign sdio_data3_oe_o = st.d3_oe;
	assign low_power_pin_zero_o = st.g0_o;
	assign low_power_pin_zero_oe_o = st.g0_oe;
	assign low_power_pin_one_oe_o = st.g1_oe;
	assign low_power_pin_five_oe_o = st.g5_oe;
	assign low_power_pin_six_o = st.g6_o;
	assign low_power_pin_six_oe_o = st.g6_oe;
	assign low_power_pin_nine_o = st.g9_o;
	assign low_power_pin_nine_oe_o = st.g9_oe;
	assign battery_domain_pin_zero_o = st.b0_o;
	assign battery_domain_pin_zero_oe_o = st.b0_oe;
	assign battery_domain_pin_three_o = st.b3_o;
	assign battery_domain_pin_three_oe_o = st.b3_oe;

	////////////////////////////////////////////////////////////////////////////
	// assertions
	property p_wlan_busy;
		@(posedge mclk_i) disable iff (!nrst_i)
		(boot_done && sel_g0 && !wr_i) |=> (low_power_pin_zero_o == $past(wlan_tx));
	endproperty
	a_wlan_busy: assert property (p_wlan_busy)
		else $error("wlan busy mismatch");
	property p_gate_high;
		@(posedge mclk_i) disable iff (!nrst_i)
		!boot_done |-> (battery_domain_pin_zero_o && battery_domain_pin_zero_oe_o);
	endproperty
	a_gate_high: assert property (p_gate_high)
		else $error("power gate not high");
	property p_boot_quiet;
		@(posedge mclk_i) disable iff (!nrst_i)
		!boot_done |-> !(sdio_data3_oe_o || low_power_pin_zero_oe_o || low_power_pin_nine_oe_o);
	endproperty
	a_boot_quiet: assert property (p_boot_quiet)
		else $error("pin driven before boot");
	property p_pkt_ready;
		@(posedge mclk_i) disable iff (!nrst_i)
		pkt_send_o |-> $past(host_powersave_wake_in) && $past(uart_mode_i);
	endproperty
	a_pkt_ready: assert property (p_pkt_ready)
		else $error("packet sent without host ready");
	property p_irq_level;
		@(posedge mclk_i) disable iff (!nrst_i)
		irq_o == |(st.irq_stat & st.irq_mask);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
	property p_wake_out;
		@(posedge mclk_i) disable iff (!nrst_i)
		low_power_pin_six_oe_o |-> $past(sel_g6 == SEL_B || wr_i);
	endproperty
	a_wake_out: assert property (p_wake_out)
		else $error("priority pin driven wrongly");
	property p_spi_irq;
		@(posedge mclk_i) disable iff (!nrst_i)
		sdio_data3_oe_o |-> $past(spi_mode_i);
	endproperty
	a_spi_irq: assert property (p_spi_irq)
		else $error("data3 driven outside spi mode");
	property p_deep_wake;
		@(posedge mclk_i) disable iff (!nrst_i)
		(boot_done && deep_sleep && boot_bypass_in && !st.pin_q[3] && !wr_i)
			|=> !deep_sleep ##0 st.irq_stat[EV_DEEP_WAKE];
	endproperty
	a_deep_wake: assert property (p_deep_wake)
		else $error("deep sleep wake missed");

	////////////////////////////////////////////////////////////////////////////
	// per-function checks on pin levels and event flags
	property p_gate_level; // gate follows sleep once booted, high before
		@(posedge mclk_i) disable iff (!nrst_i)
		battery_domain_pin_zero_o == (!boot_done || !deep_sleep);
	endproperty
	a_gate_level: assert property (p_gate_level)
		else $error("power gate level wrong");
	property p_sleep_flag; // battery pin three as sleep flag
		@(posedge mclk_i) disable iff (!nrst_i)
		battery_domain_pin_three_oe_o |-> (battery_domain_pin_three_o == !deep_sleep);
	endproperty
	a_sleep_flag: assert property (p_sleep_flag)
		else $error("sleep flag level wrong");
	property p_debug_out; // debug serial passes one flop late
		@(posedge mclk_i) disable iff (!nrst_i)
		(boot_done && !sel_g9_off && !wr_i)
			|=> low_power_pin_nine_oe_o && (low_power_pin_nine_o == $past(debug_serial_i));
	endproperty
	a_debug_out: assert property (p_debug_out)
		else $error("debug serial output wrong");
	property p_bypass_latch; // first bypass during boot is latched and flagged
		@(posedge mclk_i) disable iff (!nrst_i)
		(!boot_done && boot_bypass_in && !st.bypass_latched)
			|=> st.bypass_latched && st.irq_stat[EV_BYPASS];
	endproperty
	a_bypass_latch: assert property (p_bypass_latch)
		else $error("boot bypass not latched");
	property p_prio_event; // priority rise raises its flag
		@(posedge mclk_i) disable iff (!nrst_i)
		(sel_g6 == SEL_A && bluetooth_high_prio_in && !st.pin_q[2])
			|=> st.irq_stat[EV_BT_PRIO];
	endproperty
	a_prio_event: assert property (p_prio_event)
		else $error("priority event missed");
	property p_host_wake; // powersave wake rise raises its flag
		@(posedge mclk_i) disable iff (!nrst_i)
		(boot_done && !sel_hostrdy && host_powersave_wake_in && !st.pin_q[1])
			|=> st.irq_stat[EV_HOST_WAKE];
	endproperty
	a_host_wake: assert property (p_host_wake)
		else $error("host wake event missed");
	property p_unselected; // unselected wlan busy releases its pin
		@(posedge mclk_i) disable iff (!nrst_i)
		!sel_g0 |=> !low_power_pin_zero_oe_o;
	endproperty
	a_unselected: assert property (p_unselected)
		else $error("unselected pin still driven");
	property p_slow_clock; // slow clock passes one flop late
		@(posedge mclk_i) disable iff (!nrst_i)
		(sel_b3 == SEL_A) |=> (slow_clock_o == $past(slow_clock_in));
	endproperty
	a_slow_clock: assert property (p_slow_clock)
		else $error("slow clock not passed");
	property p_pkt_clear; // a sent packet clears its request
		@(posedge mclk_i) disable iff (!nrst_i)
		pkt_send_o |-> !st.ctrl[CT_PKT_REQ] && st.irq_stat[EV_PKT_SENT];
	endproperty
	a_pkt_clear: assert property (p_pkt_clear)
		else $error("packet request not cleared");
	property p_spi_level; // interrupt pin follows its control bit
		@(posedge mclk_i) disable iff (!nrst_i)
		sdio_data3_oe_o |-> (sdio_data3_o == st.ctrl[CT_SPI_IRQ]);
	endproperty
	a_spi_level: assert property (p_spi_level)
		else $error("spi interrupt level wrong");
endmodule : sideband_pins

// >>> far_side_model.sv
// far-side model: bluetooth transceiver, host processor and slow oscillator
// assumes the bench sets the requested levels; each pin input has one driver here
`timescale 1ns/10ps
module far_side_model #(
	parameter int HALF_NS = 400 // slow clock half period, short to keep the run brief
) (
	input wire logic nrst_i, // low while the module is held off
	input wire logic bt_busy_i, // bluetooth transmit in progress
	input wire logic bt_prio_i, // bluetooth needs precedence
	input wire logic host_sig_i, // host wake or host ready level
	input wire logic bypass_i, // bypass or deep wake level
	input wire logic clk_run_i, // oscillator enabled
	input wire logic pin6_o_i, // device level on the shared priority pin
	input wire logic pin6_oe_i, // device drives the shared priority pin
	input wire logic data3_o_i, // device level on data line three
	input wire logic data3_oe_i, // device drives data line three
	output logic pin1_o,
	output logic pin2_o,
	output logic pin3_o,
	output logic pin5_o,
	output logic pin6_o,
	output logic data3_o
);
	logic osc; // oscillator source, gated below
	////////////////////////////////////////////////////////////////////////////////
	// slow oscillator
	initial begin
		osc = 1'b0;
		forever #(HALF_NS) osc = ~osc;
	end
	////////////////////////////////////////////////////////////////////////////////
	// pin levels: every pin but data line three held at ground while the module is off
	assign pin1_o = nrst_i & bt_busy_i;
	assign pin5_o = nrst_i & host_sig_i;
	assign pin2_o = nrst_i & bypass_i;
	assign pin3_o = nrst_i & clk_run_i & osc;
	// the bluetooth priority level holds the shared pin when the device does not drive it
	assign pin6_o = pin6_oe_i ? pin6_o_i : (nrst_i & bt_prio_i);
	// pull-up holds data line three when released
	assign data3_o = data3_oe_i ? data3_o_i : 1'b1;
endmodule : far_side_model

// >>> sideband_pins_tb_top.sv
// self-checking bench for the sideband pin multiplexer
// assumes the far-side model supplies every pin input except low-power pin zero, which is looped back from its own output
`timescale 1ns/10ps
module sideband_pins_tb_top;
	import sideband_pkg::*;
	localparam logic [31:0] BOOT = 32'h1 << CT_BOOT_DONE; // keeps defaults in force
	logic mclk_i, nrst_i, wr_i, rd_i, spi_mode_i, uart_mode_i, debug_serial_i, irq_o;
	logic [3:0] addr_i;
	logic [31:0] wdata_i, rdata_o, d;
	logic pkt_send_o, slow_clock_o, d3_i, d3_o, d3_oe, p0_o, p0_oe, p1_i, p1_oe, p5_i, p5_oe;
	logic p6_i, p6_o, p6_oe, p9_o, p9_oe, b0_o, b0_oe, b2_i, b3_i, b3_o, b3_oe;
	logic [4:0] lv; // {clk_run, bypass, host_sig, bt_prio, bt_busy}
	int mismatches, total_checks, n;
	////////////////////////////////////////////////////////////////////////////////
	// design and far side
	sideband_pins uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .spi_mode_i(spi_mode_i),
		.uart_mode_i(uart_mode_i), .debug_serial_i(debug_serial_i), .pkt_send_o(pkt_send_o),
		.slow_clock_o(slow_clock_o), .sdio_data3_i(d3_i), .sdio_data3_o(d3_o),
		.sdio_data3_oe_o(d3_oe), .low_power_pin_zero_i(p0_o), .low_power_pin_zero_o(p0_o),
		.low_power_pin_zero_oe_o(p0_oe), .low_power_pin_one_i(p1_i),
		.low_power_pin_one_oe_o(p1_oe), .low_power_pin_five_i(p5_i),
		.low_power_pin_five_oe_o(p5_oe), .low_power_pin_six_i(p6_i), .low_power_pin_six_o(p6_o),
		.low_power_pin_six_oe_o(p6_oe), .low_power_pin_nine_o(p9_o),
		.low_power_pin_nine_oe_o(p9_oe), .battery_domain_pin_zero_o(b0_o),
		.battery_domain_pin_zero_oe_o(b0_oe), .battery_domain_pin_two_i(b2_i),
		.battery_domain_pin_three_i(b3_i), .battery_domain_pin_three_o(b3_o),
		.battery_domain_pin_three_oe_o(b3_oe));
	far_side_model far (.nrst_i(nrst_i), .bt_busy_i(lv[0]), .bt_prio_i(lv[1]),
		.host_sig_i(lv[2]), .bypass_i(lv[3]), .clk_run_i(lv[4]), .pin6_o_i(p6_o),
		.pin6_oe_i(p6_oe), .data3_o_i(d3_o), .data3_oe_i(d3_oe), .pin1_o(p1_i), .pin2_o(b2_i),
		.pin3_o(b3_i), .pin5_o(p5_i), .pin6_o(p6_i), .data3_o(d3_i));
	////////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results
	task automatic wr(input logic [3:0] a, input logic [31:0] w);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= w;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		check(d & m, e);
	endtask : rdchk
	task automatic settle(input int c);
		repeat (c) @(posedge mclk_i);
		#1;
	endtask : settle
	// pin levels change at an edge, then pass the synchronisers
	task automatic pins(input logic [4:0] p);
		@(posedge mclk_i);
		lv <= p;
		settle(5);
	endtask : pins
	task automatic count_hi(input int c);
		n = 0;
		repeat (c) begin
			settle(1);
			n += int'(pkt_send_o === 1'b1);
		end
	endtask : count_hi
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		check({d3_oe, p0_oe, p1_oe, p5_oe, p6_oe, p9_oe, b3_oe}, 0);
		check({b0_o, b0_oe, irq_o}, 3'b110);
		rdchk(REG_FUNC_SEL, 32'h3ff, {22'h0, FUNC_SEL_RESET});
		rdchk(REG_CTRL, 32'h3f, {26'h0, CTRL_RESET});
		wr(4'h9, 32'hffff_ffff);
		rdchk(4'h9, 32'hffff_ffff, 0);
		pins(5'b01000);
		rdchk(REG_IRQ_STAT, 32'h1 << EV_BYPASS, 32'h1 << EV_BYPASS);
		pins(0);
		wr(REG_IRQ_STAT, 32'h1f);
		rdchk(REG_IRQ_STAT, 32'h1f, 0);
	endtask : t_reset
	task automatic t_coex();
		wr(REG_FUNC_SEL, (32'h1 << FS_GPIO0) | (32'h1 << FS_GPIO1) | (32'(SEL_A) << FS_GPIO6));
		wr(REG_CTRL, BOOT | (32'h1 << CT_WLAN_TX));
		pins(5'b00011);
		check({p0_o, p0_oe, p6_oe}, 3'b110);
		rdchk(REG_STATUS, 32'h5, 32'h5);
		rdchk(REG_IRQ_STAT, 32'h1 << EV_BT_PRIO, 32'h1 << EV_BT_PRIO);
		wr(REG_CTRL, BOOT);
		pins(0);
		check({p0_o, p0_oe}, 2'b01);
		rdchk(REG_STATUS, 32'h5, 0);
		wr(REG_FUNC_SEL, 0);
		settle(2);
		check(p0_oe, 0);
		wr(REG_IRQ_STAT, 32'h1f);
		wr(REG_IRQ_MASK, 32'h1 << EV_HOST_WAKE);
		pins(5'b00100);
		check(irq_o, 1);
		wr(REG_IRQ_MASK, 0);
		settle(2);
		check(irq_o, 0);
		wr(REG_IRQ_MASK, 32'h1 << EV_HOST_WAKE);
		wr(REG_IRQ_STAT, 32'h1 << EV_HOST_WAKE);
		settle(2);
		check(irq_o, 0);
		pins(0);
	endtask : t_coex
	task automatic t_outputs();
		wr(REG_FUNC_SEL, (32'(SEL_B) << FS_GPIO6) | (32'h1 << FS_DATA3));
		spi_mode_i <= 1'b1;
		wr(REG_CTRL, BOOT | (32'h1 << CT_HOST_WAKE) | (32'h1 << CT_SPI_IRQ));
		settle(2);
		check({p6_o, p6_oe, d3_o, d3_oe}, 4'b1111);
		wr(REG_CTRL, BOOT);
		settle(2);
		check({p6_o, p6_oe, d3_o, d3_oe}, 4'b0101);
		@(posedge mclk_i);
		spi_mode_i <= 1'b0;
		wr(REG_FUNC_SEL, 32'(SEL_B) << FS_BATT3);
		wr(REG_CTRL, BOOT | (32'h1 << CT_DEEP_SLEEP));
		settle(2);
		check({b0_o, b0_oe, b3_o, b3_oe}, 4'b0101);
		pins(5'b01000);
		check({b0_o, b0_oe, b3_o, b3_oe}, 4'b1111);
		rdchk(REG_CTRL, 32'h1 << CT_DEEP_SLEEP, 0);
		rdchk(REG_IRQ_STAT, 32'h1 << EV_DEEP_WAKE, 32'h1 << EV_DEEP_WAKE);
		pins(0);
		wr(REG_FUNC_SEL, 32'h1 << FS_BATT0);
		wr(REG_CTRL, BOOT | (32'h1 << CT_DEEP_SLEEP));
		settle(2);
		check({b0_o, b0_oe, b3_oe}, 3'b010);
		wr(REG_CTRL, BOOT);
		settle(2);
		check({b0_o, b0_oe}, 2'b11);
	endtask : t_outputs
	task automatic t_packet();
		@(posedge mclk_i);
		uart_mode_i <= 1'b1;
		wr(REG_FUNC_SEL, (32'h1 << FS_PIN5) | (32'(SEL_A) << FS_BATT3));
		wr(REG_CTRL, BOOT | (32'h1 << CT_PKT_REQ));
		count_hi(8);
		check(n, 0);
		@(posedge mclk_i);
		lv <= 5'b00100;
		count_hi(12);
		check(n, 1);
		rdchk(REG_CTRL, 32'h1 << CT_PKT_REQ, 0);
		rdchk(REG_IRQ_STAT, 32'h1 << EV_PKT_SENT, 32'h1 << EV_PKT_SENT);
		pins(5'b10000);
		n = 0;
		repeat (80) begin
			settle(1);
			n += int'(slow_clock_o === 1'b1);
		end
		check({b3_oe, 1'(n > 10 && n < 70)}, 2'b01);
		@(posedge mclk_i);
		debug_serial_i <= 1'b1;
		settle(3);
		check({p9_o, p9_oe}, 2'b11);
		@(posedge mclk_i);
		debug_serial_i <= 1'b0;
		settle(3);
		check({p9_o, p9_oe}, 2'b01);
		wr(REG_FUNC_SEL, 32'h1 << FS_GPIO9);
		settle(2);
		check(p9_oe, 0);
	endtask : t_packet
	////////////////////////////////////////////////////////////////////////////////
	// clock and main sequence
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	initial begin
		{nrst_i, wr_i, rd_i, spi_mode_i, uart_mode_i, debug_serial_i} = 6'h00;
		addr_i = 4'h0;
		wdata_i = 32'h0;
		lv = 5'h00;
		mismatches = 0;
		total_checks = 0;
		repeat (12) @(posedge mclk_i);
		nrst_i <= 1'b1;
		settle(2);
		t_reset();
		t_coex();
		t_outputs();
		t_packet();
		results();
	end
endmodule : sideband_pins_tb_top
